// file: bench/tsm_pin_model.sv
// Far-side model of the external count and interrupt input pins
`timescale 1ns/100ps
`default_nettype none
module tsm_pin_model (
  // Clock
  input  wire logic ref_clk,
  // Pins
  output var  logic count_a_pin,
  output var  logic ext_irq_a_input,
  output var  logic ext_irq_b_input
);
  initial begin
    count_a_pin     = 1'b1;
    ext_irq_a_input = 1'b0;
    ext_irq_b_input = 1'b0;
  end
  // Falling edges on the count pin, each level held four clocks
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      count_a_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
      count_a_pin = 1'b1;
      repeat (3) @(negedge ref_clk);
    end
  endtask : pulses
  task automatic irq(input logic a, input logic b);
    @(negedge ref_clk);
    ext_irq_a_input = a;
    ext_irq_b_input = b;
  endtask : irq
endmodule : tsm_pin_model
`default_nettype wire

// file: bench/tsm_timer_ctl_tb.sv
// Testbench for the split-mode timer pair and its control register
`timescale 1ns/100ps
`default_nettype none
module tsm_timer_ctl_tb;
  logic       ref_clk, rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, rv;
  logic [1:0] a_mode, b_mode;
  logic       a_cs, a_gate, a_sys, b_sys, irq_a_hi, irq_b_hi, ack_ta, ack_tb, ack_eb;
  logic       ack_ea, b_cs, presc;
  logic       cnt_pin, irq_a_in, irq_b_in, tf0, tf1, ie0, ie1, b_pulse;
  int         errors, checks, pulse_cnt, c0;

  tsm_pin_model pm (.ref_clk(ref_clk), .count_a_pin(cnt_pin), .ext_irq_a_input(irq_a_in),
    .ext_irq_b_input(irq_b_in));
  tsm_timer_ctl dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
    .timer_a_mode(a_mode), .timer_b_mode(b_mode), .timer_a_count_select(a_cs),
    .timer_a_gate_enable(a_gate), .timer_b_count_select(b_cs), .timer_b_gate_enable(1'b0),
    .timer_a_sysclk_sel(a_sys), .timer_b_sysclk_sel(b_sys), .presc_tick(presc),
    .ext_irq_a_active_high(irq_a_hi), .ext_irq_b_active_high(irq_b_hi),
    .vec_ack_timer_a(ack_ta), .vec_ack_timer_b(ack_tb), .vec_ack_ext_a(ack_ea),
    .vec_ack_ext_b(ack_eb), .count_a_pin(cnt_pin), .count_b_pin(1'b1),
    .ext_irq_a_input(irq_a_in), .ext_irq_b_input(irq_b_in), .timer_a_overflow_flag(tf0),
    .timer_b_overflow_flag(tf1), .ext_irq_a_flag(ie0), .ext_irq_b_flag(ie1),
    .timer_b_ovf_pulse(b_pulse));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (b_pulse === 1'b1) pulse_cnt++;

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic bw(input logic [7:0] a, input logic v);
    @(negedge ref_clk);
    {sfr_bit_wr, sfr_bit_addr, sfr_bit_val} = {1'b1, a, v};
    @(negedge ref_clk);
    sfr_bit_wr = 1'b0;
  endtask : bw
  // Bounded wait: 0 first flag, 1 second flag, 2 second timer pulse
  task automatic wait_on(input int w);
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      if (w == 0 && tf0 === 1'b1) break;
      if (w == 1 && tf1 === 1'b1) break;
      if (w == 2 && pulse_cnt != c0) break;
    end
  endtask : wait_on
  task automatic pulse(input int w);
    @(negedge ref_clk);
    {ack_ta, ack_tb, ack_eb, ack_ea} = 4'b1000 >> w;
    @(negedge ref_clk);
    {ack_ta, ack_tb, ack_eb, ack_ea} = 4'b0000;
  endtask : pulse
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  initial begin
    {rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
    {a_mode, b_mode} = {tsm_pkg::MODE_SPLIT, tsm_pkg::MODE_SPLIT};
    {a_cs, a_gate, a_sys, b_sys, irq_a_hi, irq_b_hi} = 6'b001111;
    {ack_ta, ack_tb, ack_eb, ack_ea, b_cs, presc} = 6'b000000;
    {errors, checks, pulse_cnt, c0} = '0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(tsm_pkg::TIMER_CONTROL_ADDR, rv);
    chk("control reset", rv, tsm_pkg::TIMER_CONTROL_RST);
    rd(8'hff, rv);
    chk("unmapped", rv, 8'h00);
    $display("test reset done");
    wr(8'hc0, 8'hfe);
    wr(8'hc1, 8'h00);
    bw(8'h8c, 1'b1);
    wait_on(0);
    chk("low byte wrap flag", {7'h0, tf0}, 8'h01);
    rd(8'hc1, rv);
    chk("high byte idle", rv, 8'h00);
    chk("second flag idle", {7'h0, tf1}, 8'h00);
    bw(8'h8c, 1'b0);
    rd(8'h88, rv);
    chk("control flag bit5", rv, 8'h20);
    pulse(0);
    chk("vector clears first", {7'h0, tf0}, 8'h00);
    $display("test low byte done");
    a_cs = 1'b1;
    wr(8'hc0, 8'h10);
    bw(8'h8c, 1'b1);
    pm.pulses(5);
    rd(8'hc0, rv);
    chk("pin count", rv, 8'h15);
    a_gate = 1'b1;
    pm.irq(1'b0, 1'b0);
    pm.pulses(3);
    rd(8'hc0, rv);
    chk("gated off", rv, 8'h15);
    pm.irq(1'b1, 1'b0);
    pm.pulses(2);
    rd(8'hc0, rv);
    chk("gated on", rv, 8'h17);
    bw(8'h8c, 1'b0);
    a_gate = 1'b0;
    chk("first ext flag", {7'h0, ie0}, 8'h01);
    pm.irq(1'b0, 1'b0);
    repeat (3) @(negedge ref_clk);
    pulse(3);
    chk("vector clears first irq", {7'h0, ie0}, 8'h00);
    $display("test pin count done");
    a_sys = 1'b0;
    wr(8'hc1, 8'h33);
    bw(8'h8e, 1'b1);
    pm.pulses(3);
    rd(8'hc1, rv);
    chk("high byte no pin", rv, 8'h33);
    repeat (4) begin
      @(negedge ref_clk);
      presc = 1'b1;
      @(negedge ref_clk);
      presc = 1'b0;
    end
    rd(8'hc1, rv);
    chk("high byte prescaled", rv, 8'h37);
    bw(8'h8e, 1'b0);
    {a_cs, a_sys} = 2'b01;
    wr(8'hc0, 8'h40);
    wr(8'hc1, 8'hfe);
    bw(8'h8e, 1'b1);
    wait_on(1);
    chk("high byte sets second flag", {7'h0, tf1}, 8'h01);
    bw(8'h8e, 1'b0);
    rd(8'hc0, rv);
    chk("low byte independent", rv, 8'h40);
    rd(8'h88, rv);
    chk("control flag bit7", rv, 8'h80);
    pulse(1);
    chk("vector clears second", {7'h0, tf1}, 8'h00);
    $display("test high byte done");
    b_cs = 1'b1;
    for (int m = 0; m < 3; m++) begin
      wr(8'hc2, 8'hff);
      wr(8'hc3, 8'hff);
      c0 = pulse_cnt;
      b_mode = m[1:0];
      wait_on(2);
      chk("second timer pulse", 8'(pulse_cnt != c0), 8'h01);
      chk("second timer no flag", {7'h0, tf1}, 8'h00);
      b_mode = tsm_pkg::MODE_SPLIT;
    end
    b_cs = 1'b0;
    wr(8'hc2, 8'h77);
    repeat (10) @(negedge ref_clk);
    rd(8'hc2, rv);
    chk("second timer halted", rv, 8'h77);
    $display("test second timer done");
    bw(8'h8a, 1'b1);
    pm.irq(1'b1, 1'b1);
    repeat (6) @(negedge ref_clk);
    chk("edge flag set", {7'h0, ie1}, 8'h01);
    bw(8'h8b, 1'b0);
    repeat (3) @(negedge ref_clk);
    chk("edge flag cleared", {7'h0, ie1}, 8'h00);
    bw(8'h8a, 1'b0);
    repeat (2) @(negedge ref_clk);
    chk("level flag set", {7'h0, ie1}, 8'h01);
    pm.irq(1'b1, 1'b0);
    repeat (6) @(negedge ref_clk);
    pulse(2);
    chk("vector clears irq", {7'h0, ie1}, 8'h00);
    irq_b_hi = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("active low level", {7'h0, ie1}, 8'h01);
    $display("test ext irq done");
    summarize();
  end
endmodule : tsm_timer_ctl_tb
`default_nettype wire

// file: logic/tsm_pkg.sv
// Constants for the timer pair split mode and the shared timer control register
package tsm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
  localparam logic [7:0] TIMER_A_LOW_ADDR   = 8'hc0;
  localparam logic [7:0] TIMER_A_HIGH_ADDR  = 8'hc1;
  localparam logic [7:0] TIMER_B_LOW_ADDR   = 8'hc2;
  localparam logic [7:0] TIMER_B_HIGH_ADDR  = 8'hc3;
  localparam logic [7:0] TIMER_CONTROL_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST          = 8'h00;

  // ---------------------------------------------------------------
  // Timer control fields
  // ---------------------------------------------------------------
  localparam int TB_OVF_BIT  = 7;
  localparam int TB_RUN_BIT  = 6;
  localparam int TA_OVF_BIT  = 5;
  localparam int TA_RUN_BIT  = 4;
  localparam int EB_FLAG_BIT = 3;
  localparam int EB_TYPE_BIT = 2;
  localparam int EA_FLAG_BIT = 1;
  localparam int EA_TYPE_BIT = 0;

  // ---------------------------------------------------------------
  // Timer modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;
  localparam logic [7:0] BYTE_ONES   = 8'hff;
  localparam logic [4:0] LOW13_ONES  = 5'h1f;

endpackage : tsm_pkg

// file: logic/tsm_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module tsm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Pin side
  input  wire logic [W-1:0] pin_in,
  // Synchronous side
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end

endmodule : tsm_sync
`default_nettype wire

// file: logic/tsm_timer_ctl.sv
// Timer pair with split mode for the first timer and the shared timer control register
//
// Contract
// - Split mode runs the first timer's low and high bytes as two 8-bit counters.
// - Low byte uses first timer's run, count-select, gate and overflow flag.
// - Low byte counts system or prescaled clock, or external count input, per count-select.
// - High byte is a timer only: system or prescaled clock, never a pin.
// - High byte counts only while the second timer's run bit is set.
// - High byte overflow sets the second timer's overflow flag.
// - In split mode second timer runs modes 0-2, no pin clock, no flag.
// - Second timer overflow pulses still reach serial ports and converter.
// - In split mode second timer runs for mode 0, 1, 2 and halts for 3.
// - Overflow flags set by hardware, cleared by software or vectoring.
// - Run bit 0 disables its counter, 1 enables it; in split mode the second run bit drives the high byte.
// - Second external interrupt flag set on chosen edge or level, cleared by software or vectoring.
// - First timer runs when run bit set and gate off or input active.
`timescale 1ns/100ps
`default_nettype none
module tsm_timer_ctl (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic [7:0] sfr_bit_addr,
  input  wire logic       sfr_bit_val,
  output var  logic [7:0] sfr_rdata,
  // Mode and clock configuration
  input  wire logic [1:0] timer_a_mode,
  input  wire logic [1:0] timer_b_mode,
  input  wire logic       timer_a_count_select,
  input  wire logic       timer_a_gate_enable,
  input  wire logic       timer_b_count_select,
  input  wire logic       timer_b_gate_enable,
  input  wire logic       timer_a_sysclk_sel,
  input  wire logic       timer_b_sysclk_sel,
  input  wire logic       presc_tick,
  input  wire logic       ext_irq_a_active_high,
  input  wire logic       ext_irq_b_active_high,
  // Vectoring acknowledges
  input  wire logic       vec_ack_timer_a,
  input  wire logic       vec_ack_timer_b,
  input  wire logic       vec_ack_ext_a,
  input  wire logic       vec_ack_ext_b,
  // Pins
  input  wire logic       count_a_pin,
  input  wire logic       count_b_pin,
  input  wire logic       ext_irq_a_input,
  input  wire logic       ext_irq_b_input,
  // Flags and pulses
  output var  logic       timer_a_overflow_flag,
  output var  logic       timer_b_overflow_flag,
  output var  logic       ext_irq_a_flag,
  output var  logic       ext_irq_b_flag,
  output var  logic       timer_b_ovf_pulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] timer_a_low_byte;
    logic [7:0] timer_a_high_byte;
    logic [7:0] timer_b_low;
    logic [7:0] timer_b_high;
    logic [7:0] rdata;
    logic       b_pulse;
    logic [3:0] pin_prev;
  } tsm_state_t;

  tsm_state_t st_r;
  tsm_state_t st_nxt;
  logic [3:0] pin_s;

  tsm_sync #(.W(4)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   ({ext_irq_b_input, ext_irq_a_input, count_b_pin, count_a_pin}),
    .sync_out (pin_s)
  );

  // ---------------------------------------------------------------
  // Clock sources and enables
  // ---------------------------------------------------------------
  logic split, cnt_a_fall, cnt_b_fall, int_a_act, int_b_act, int_a_prev_act;
  logic int_b_prev_act, run_a, run_b, en_a, en_b, int_tick_a, int_tick_b;
  logic tick_a, tick_b, hi_step, lo_step, b_step, lo_ovf, hi_ovf, b_ovf;
  logic [16:0] a_res, b_res;

  assign split          = (timer_a_mode == tsm_pkg::MODE_SPLIT);
  assign cnt_a_fall     = st_r.pin_prev[0] & ~pin_s[0];
  assign cnt_b_fall     = st_r.pin_prev[1] & ~pin_s[1];
  assign int_a_act      = ~(pin_s[2] ^ ext_irq_a_active_high);
  assign int_b_act      = ~(pin_s[3] ^ ext_irq_b_active_high);
  assign int_a_prev_act = ~(st_r.pin_prev[2] ^ ext_irq_a_active_high);
  assign int_b_prev_act = ~(st_r.pin_prev[3] ^ ext_irq_b_active_high);
  assign run_a          = st_r.timer_control[tsm_pkg::TA_RUN_BIT];
  assign run_b          = st_r.timer_control[tsm_pkg::TB_RUN_BIT];
  assign int_tick_a     = timer_a_sysclk_sel | presc_tick;
  assign int_tick_b     = timer_b_sysclk_sel | presc_tick;
  assign en_a           = run_a & (~timer_a_gate_enable | int_a_act);
  assign en_b           = run_b & (~timer_b_gate_enable | int_b_act);
  assign tick_a         = timer_a_count_select ? cnt_a_fall : int_tick_a;
  // No pin clock for second timer in split mode
  assign tick_b         = (timer_b_count_select & ~split) ? cnt_b_fall : int_tick_b;
  // Low byte steered by first timer's controls
  assign lo_step        = en_a & tick_a;
  // High byte internal clock only, run by second run bit
  assign hi_step        = split & run_b & int_tick_a;
  // Second timer runs by its mode while split, else by its run bit
  assign b_step         = split ? ((timer_b_mode != tsm_pkg::MODE_SPLIT) & tick_b)
                                : (en_b & tick_b);
  // Split bytes wrap on all ones
  assign lo_ovf         = lo_step & (st_r.timer_a_low_byte == tsm_pkg::BYTE_ONES);
  assign hi_ovf         = hi_step & (st_r.timer_a_high_byte == tsm_pkg::BYTE_ONES);

  // One step of a timer in mode 0, 1 or 2; returns overflow, high, low
  function automatic logic [16:0] step(input logic [1:0] md, input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (md)
      tsm_pkg::MODE_13BIT: begin
        if (lo[4:0] == tsm_pkg::LOW13_ONES) begin
          r = {(hi == tsm_pkg::BYTE_ONES), 8'(hi + 8'h01), lo[7:5], 5'h00};
        end else begin
          r = {1'b0, hi, lo[7:5], 5'(lo[4:0] + 5'h01)};
        end
      end
      tsm_pkg::MODE_RELOAD: begin
        if (lo == tsm_pkg::BYTE_ONES) begin
          r = {1'b1, hi, hi};
        end else begin
          r = {1'b0, hi, 8'(lo + 8'h01)};
        end
      end
      default: begin
        r = {1'b0, 16'({hi, lo} + 16'h0001)};
        r[16] = ({hi, lo} == 16'hffff);
      end
    endcase
    return r;
  endfunction : step

  assign a_res = step(timer_a_mode, st_r.timer_a_high_byte, st_r.timer_a_low_byte);
  assign b_res = step(timer_b_mode, st_r.timer_b_high, st_r.timer_b_low);
  assign b_ovf = b_step & b_res[16];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [7:0] tc_sw;
  logic       a_ovf_set, b_flag_set, ea_set, eb_set;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.pin_prev = pin_s;
    st_nxt.rdata    = st_r.rdata;
    tc_sw           = st_r.timer_control;
    // Software access, byte then bit
    if (sfr_wr && sfr_addr == tsm_pkg::TIMER_CONTROL_ADDR) begin
      tc_sw = sfr_wdata;
    end
    if (sfr_bit_wr && sfr_bit_addr[7:3] == tsm_pkg::TIMER_CONTROL_ADDR[7:3]) begin
      tc_sw[sfr_bit_addr[2:0]] = sfr_bit_val;
    end
    if (vec_ack_timer_a) begin
      tc_sw[tsm_pkg::TA_OVF_BIT] = 1'b0;
    end
    if (vec_ack_timer_b) begin
      tc_sw[tsm_pkg::TB_OVF_BIT] = 1'b0;
    end
    if (vec_ack_ext_a) begin
      tc_sw[tsm_pkg::EA_FLAG_BIT] = 1'b0;
    end
    if (vec_ack_ext_b) begin
      tc_sw[tsm_pkg::EB_FLAG_BIT] = 1'b0;
    end
    // Counters
    if (split) begin
      if (lo_step) begin
        st_nxt.timer_a_low_byte = 8'(st_r.timer_a_low_byte + 8'h01);
      end
      if (hi_step) begin
        st_nxt.timer_a_high_byte = 8'(st_r.timer_a_high_byte + 8'h01);
      end
      a_ovf_set = lo_ovf;
      // High byte owns the second flag; second timer does not
      b_flag_set = hi_ovf;
    end else begin
      if (lo_step) begin
        {st_nxt.timer_a_high_byte, st_nxt.timer_a_low_byte} = a_res[15:0];
      end
      a_ovf_set  = lo_step & a_res[16];
      b_flag_set = b_ovf;
    end
    if (b_step && timer_b_mode != tsm_pkg::MODE_SPLIT) begin
      {st_nxt.timer_b_high, st_nxt.timer_b_low} = b_res[15:0];
    end
    // Edge or level detection per type select
    ea_set = st_r.timer_control[tsm_pkg::EA_TYPE_BIT] ? (int_a_act & ~int_a_prev_act)
                                                      : int_a_act;
    eb_set = st_r.timer_control[tsm_pkg::EB_TYPE_BIT] ? (int_b_act & ~int_b_prev_act)
                                                      : int_b_act;
    // Hardware set wins over any clear
    if (a_ovf_set) begin
      tc_sw[tsm_pkg::TA_OVF_BIT] = 1'b1;
    end
    if (b_flag_set) begin
      tc_sw[tsm_pkg::TB_OVF_BIT] = 1'b1;
    end
    if (ea_set) begin
      tc_sw[tsm_pkg::EA_FLAG_BIT] = 1'b1;
    end
    if (eb_set) begin
      tc_sw[tsm_pkg::EB_FLAG_BIT] = 1'b1;
    end
    st_nxt.timer_control = tc_sw;
    // Software byte writes to counters take priority over counting
    if (sfr_wr) begin
      case (sfr_addr)
        tsm_pkg::TIMER_A_LOW_ADDR:  st_nxt.timer_a_low_byte  = sfr_wdata;
        tsm_pkg::TIMER_A_HIGH_ADDR: st_nxt.timer_a_high_byte = sfr_wdata;
        tsm_pkg::TIMER_B_LOW_ADDR:  st_nxt.timer_b_low       = sfr_wdata;
        tsm_pkg::TIMER_B_HIGH_ADDR: st_nxt.timer_b_high      = sfr_wdata;
        default: ;
      endcase
    end
    if (sfr_rd) begin
      case (sfr_addr)
        tsm_pkg::TIMER_CONTROL_ADDR: st_nxt.rdata = st_r.timer_control;
        tsm_pkg::TIMER_A_LOW_ADDR:   st_nxt.rdata = st_r.timer_a_low_byte;
        tsm_pkg::TIMER_A_HIGH_ADDR:  st_nxt.rdata = st_r.timer_a_high_byte;
        tsm_pkg::TIMER_B_LOW_ADDR:   st_nxt.rdata = st_r.timer_b_low;
        tsm_pkg::TIMER_B_HIGH_ADDR:  st_nxt.rdata = st_r.timer_b_high;
        default:                     st_nxt.rdata = 8'h00;
      endcase
    end
    // Second timer overflow always pulses out
    st_nxt.b_pulse = b_ovf;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{timer_control: tsm_pkg::TIMER_CONTROL_RST, timer_a_low_byte: tsm_pkg::COUNT_RST,
                timer_a_high_byte: tsm_pkg::COUNT_RST, timer_b_low: tsm_pkg::COUNT_RST,
                timer_b_high: tsm_pkg::COUNT_RST, rdata: 8'h00, b_pulse: 1'b0,
                pin_prev: 4'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata             = st_r.rdata;
  assign timer_a_overflow_flag = st_r.timer_control[tsm_pkg::TA_OVF_BIT];
  assign timer_b_overflow_flag = st_r.timer_control[tsm_pkg::TB_OVF_BIT];
  assign ext_irq_a_flag        = st_r.timer_control[tsm_pkg::EA_FLAG_BIT];
  assign ext_irq_b_flag        = st_r.timer_control[tsm_pkg::EB_FLAG_BIT];
  assign timer_b_ovf_pulse     = st_r.b_pulse;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic any_wr;
  assign any_wr = sfr_wr | sfr_bit_wr;

  hi_indep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && !run_b && !any_wr |=> $stable(st_r.timer_a_high_byte))
    else $error("high byte moved while its run bit was clear");
  lo_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && timer_a_gate_enable && !int_a_act && !any_wr |=> $stable(st_r.timer_a_low_byte))
    else $error("low byte moved while gated off");
  lo_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && run_a && timer_a_count_select && !cnt_a_fall && !any_wr
    |=> $stable(st_r.timer_a_low_byte))
    else $error("low byte counted without a pin edge");
  hi_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && run_b && !timer_a_sysclk_sel && !presc_tick && !any_wr
    |=> $stable(st_r.timer_a_high_byte))
    else $error("high byte counted without an internal tick");
  hi_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && run_b && timer_a_sysclk_sel && !any_wr
    |=> st_r.timer_a_high_byte == 8'($past(st_r.timer_a_high_byte) + 8'h01))
    else $error("high byte failed to count while run");
  hi_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hi_ovf |=> timer_b_overflow_flag && st_r.timer_a_high_byte == 8'h00)
    else $error("high byte overflow did not set second flag");
  b_noflag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && !hi_ovf && !timer_b_overflow_flag && !any_wr |=> !timer_b_overflow_flag)
    else $error("second timer set its flag in split mode");
  b_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    b_step && b_res[16] |=> timer_b_ovf_pulse ##1 (!timer_b_ovf_pulse || $past(b_ovf)))
    else $error("second timer overflow pulse missing");
  b_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    split && timer_b_mode == tsm_pkg::MODE_SPLIT && !sfr_wr
    |=> $stable({st_r.timer_b_high, st_r.timer_b_low}))
    else $error("second timer ran in mode 3");
  ack_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    vec_ack_timer_a && !a_ovf_set |=> !timer_a_overflow_flag)
    else $error("vectoring did not clear first flag");
  run_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !run_a && !sfr_wr |=> $stable(st_r.timer_a_low_byte))
    else $error("first timer counted while disabled");
  ext_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    eb_set |=> ext_irq_b_flag)
    else $error("second external flag not set");
  wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lo_ovf && split && !sfr_wr |=> st_r.timer_a_low_byte == 8'h00 && timer_a_overflow_flag)
    else $error("split low byte did not wrap with flag");

endmodule : tsm_timer_ctl
`default_nettype wire
